/* hdl/ftsram_pkg.sv */
// shared types and constants for the flow-through sram data path
package ftsram_pkg;
   localparam int LANES = 4; // byte lanes, each with one parity bit
   localparam int BYTE_W = 8; // data bits per lane
   localparam int DATA_W = LANES * BYTE_W; // plain data bits
   localparam int WORD_W = DATA_W + LANES; // data plus parity bits
   localparam int ADDR_W = 18; // word address width
   localparam int BURST_W = 2; // burst counter width
   localparam logic [1:0] BURST_ZERO = 2'h0; // counter value after load
   localparam logic [1:0] BURST_ONE = 2'h1; // counter step
   localparam logic INTERLEAVED_RST = 1'b1; // interleaved order held until the strap is latched
   localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0_0000_0000; // cleared word

   // one word on the data pins, parity lanes above data lanes
   typedef struct packed {
      logic [LANES-1:0] parity; // one parity bit per lane
      logic [DATA_W-1:0] data; // lane i is data[8i+7:8i]
   } ftsram_word_t;

   // synchronous controls from the memory controller
   typedef struct packed {
      logic clock_qualifier_n; // low: edge is recognised
      logic chip_select_one_n; // low selects
      logic chip_select_two; // high selects
      logic chip_select_three_n; // low selects
      logic advance_or_load; // high advances burst, low loads address
      logic write_enable_n; // low starts a write sequence
      logic [LANES-1:0] byte_write_select_n; // low writes that lane
   } ftsram_ctrl_t;

   // access kind in progress
   typedef enum logic [1:0] {
      FTSRAM_DESEL,
      FTSRAM_READ,
      FTSRAM_WRITE
   } ftsram_op_t;
endpackage : ftsram_pkg

/* hdl/ftsram_burst_ctr.sv */
// two-bit burst counter producing the low address bits
`timescale 1ns/1ps
`default_nettype none
module ftsram_burst_ctr (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic step_en,
   input wire logic load,
   input wire logic interleaved,
   input wire logic [ftsram_pkg::BURST_W-1:0] start,
   output logic [ftsram_pkg::BURST_W-1:0] offset
);
   logic [ftsram_pkg::BURST_W-1:0] start_r; // offset loaded at burst start
   logic [ftsram_pkg::BURST_W-1:0] count_r; // running burst count
   logic [ftsram_pkg::BURST_W-1:0] count_nxt; // count for this edge
   logic [ftsram_pkg::BURST_W-1:0] lin_off; // linear sequence offset
   logic [ftsram_pkg::BURST_W-1:0] il_off; // interleaved sequence offset

   // load restarts at zero, an advance steps by one
   assign count_nxt = load ? ftsram_pkg::BURST_ZERO : count_r + ftsram_pkg::BURST_ONE;
   assign lin_off = start_r + count_nxt;
   assign il_off = start_r ^ count_nxt;
   // at a load edge the pins give the address directly
   assign offset = load ? start : (interleaved ? il_off : lin_off);

   // counter moves only on recognised edges
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         start_r <= ftsram_pkg::BURST_ZERO;
         count_r <= ftsram_pkg::BURST_ZERO;
      end else if (step_en) begin
         if (load) begin
            start_r <= start;
         end
         count_r <= count_nxt;
      end
   end
endmodule : ftsram_burst_ctr
`default_nettype wire

/* hdl/ftsram_data_io.sv */
// data path of a flow-through burst sram: capture, read, three-state
`timescale 1ns/1ps
`default_nettype none
// Contract
// - input pins captured on rising edge
// - read data follows previous edge's address
// - output enable low lets pins drive
// - output enable high floats all pins
// - write data phase always floats pins
// - deselected and emerging cycle float pins
// - parity lines behave like data lines
// - parity stored only with its byte select
// - strap low gives linear burst order
// - strap high or open gives interleaved; an open strap is interleaved only until the latch after reset
// - byte selects with write strobe pick lanes
// - qualifier high stalls without deselecting
// - low address bits feed burst counter
module ftsram_data_io #(
   parameter int ADDR_W = ftsram_pkg::ADDR_W
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire ftsram_pkg::ftsram_ctrl_t ctrl,
   input wire logic output_enable_n,
   input wire logic burst_order_strap,
   input wire ftsram_pkg::ftsram_word_t data_in,
   output ftsram_pkg::ftsram_word_t data_out,
   output logic [ftsram_pkg::WORD_W-1:0] data_oe
);
   localparam int DEPTH = 1 << ADDR_W; // words of storage
   localparam int LO_W = ftsram_pkg::BURST_W; // low address bits

   logic [ftsram_pkg::WORD_W-1:0] mem_q [DEPTH]; // storage array
   ftsram_pkg::ftsram_op_t op_r; // access kind of current cycle
   ftsram_pkg::ftsram_op_t op_nxt; // access kind taken at this edge
   logic drive_r; // read data phase in progress
   ftsram_pkg::ftsram_word_t rd_r; // read data register
   logic [ADDR_W-LO_W-1:0] addr_hi_r; // high address bits of burst
   logic wr_pend_r; // next edge is a write data phase
   logic [ADDR_W-1:0] wr_addr_r; // address of pending write
   logic [ftsram_pkg::LANES-1:0] wr_lanes_n_r; // lane selects of pending write
   logic strap_meta_r; // strap synchroniser first stage
   logic strap_sync_r; // strap synchroniser second stage
   logic strap_taken_r; // strap has been latched
   logic interleaved_r; // latched burst order

   // decoded controls
   wire en = ~ctrl.clock_qualifier_n; // recognised edge
   wire load = ~ctrl.advance_or_load; // new address this edge
   wire sel_now = ~ctrl.chip_select_one_n & ctrl.chip_select_two & ~ctrl.chip_select_three_n;
   wire [LO_W-1:0] burst_lo; // low address bits for this edge
   wire [ADDR_W-1:0] cur_addr = {(load ? address[ADDR_W-1:LO_W] : addr_hi_r), burst_lo};
   wire wr_hit = wr_pend_r & (wr_addr_r == cur_addr); // read meets write in flight
   wire [ftsram_pkg::WORD_W-1:0] wr_word; // stored word after lane merge
   wire [ftsram_pkg::WORD_W-1:0] rd_word; // read word with write bypass

   // burst counter on low address bits
   ftsram_burst_ctr u_burst (
      .clock(clock),
      .rst_n(rst_n),
      .step_en(en),
      .load(load),
      .interleaved(interleaved_r),
      .start(address[LO_W-1:0]),
      .offset(burst_lo)
   );

   // access kind: load decodes selects, advance continues
   always_comb begin
      if (load) begin
         if (!sel_now) begin
            op_nxt = ftsram_pkg::FTSRAM_DESEL;
         end else if (ctrl.write_enable_n) begin
            op_nxt = ftsram_pkg::FTSRAM_READ;
         end else begin
            op_nxt = ftsram_pkg::FTSRAM_WRITE;
         end
      end else begin
         op_nxt = op_r; // burst keeps kind, deselect stays
      end
   end

   // per-lane merge of captured pins into old word
   for (genvar i = 0; i < ftsram_pkg::LANES; i++) begin : g_lane
      wire take = ~wr_lanes_n_r[i]; // lane chosen by its select
      assign wr_word[i*ftsram_pkg::BYTE_W +: ftsram_pkg::BYTE_W] = take ?
         data_in.data[i*ftsram_pkg::BYTE_W +: ftsram_pkg::BYTE_W] :
         mem_q[wr_addr_r][i*ftsram_pkg::BYTE_W +: ftsram_pkg::BYTE_W];
      assign wr_word[ftsram_pkg::DATA_W + i] = take ? data_in.parity[i] :
         mem_q[wr_addr_r][ftsram_pkg::DATA_W + i];
   end
   assign rd_word = wr_hit ? wr_word : mem_q[cur_addr];

   // write data phase stores captured pins
   always_ff @(posedge clock) begin
      if (en && wr_pend_r) begin
         mem_q[wr_addr_r] <= wr_word;
      end
   end

   // access sequencing and read data register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         op_r <= ftsram_pkg::FTSRAM_DESEL;
         drive_r <= 1'b0;
         rd_r <= ftsram_pkg::WORD_ZERO;
         addr_hi_r <= '0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         wr_lanes_n_r <= '1;
      end else if (en) begin
         op_r <= op_nxt;
         drive_r <= (op_nxt == ftsram_pkg::FTSRAM_READ);
         wr_pend_r <= (op_nxt == ftsram_pkg::FTSRAM_WRITE);
         wr_addr_r <= cur_addr;
         if (load) begin
            addr_hi_r <= address[ADDR_W-1:LO_W];
            wr_lanes_n_r <= ctrl.byte_write_select_n;
         end
         if (op_nxt == ftsram_pkg::FTSRAM_READ) begin
            rd_r <= rd_word;
         end
      end
   end

   // burst order strap: synchronise, then latch once after reset
   always_ff @(posedge clock) begin
      strap_meta_r <= burst_order_strap;
      strap_sync_r <= strap_meta_r;
      if (!rst_n) begin
         strap_taken_r <= 1'b0;
         interleaved_r <= ftsram_pkg::INTERLEAVED_RST;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         interleaved_r <= strap_sync_r;
      end
   end

   // pins drive only in a read phase with output enable low
   assign data_out = rd_r;
   assign data_oe = {ftsram_pkg::WORD_W{drive_r & ~output_enable_n}};

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence write_addr_s;
      en && op_nxt == ftsram_pkg::FTSRAM_WRITE;
   endsequence
   sequence linear_load_s;
      en && load && !interleaved_r && strap_taken_r;
   endsequence
   sequence il_load_s;
      en && load && interleaved_r && strap_taken_r;
   endsequence

   capture_lane_zero_a: assert property (
      en && wr_pend_r && !wr_lanes_n_r[0]
      |=> mem_q[$past(wr_addr_r)][7:0] == $past(data_in.data[7:0]))
      else $error("lane zero data not captured");
   parity_lane_three_a: assert property (
      en && wr_pend_r
      |=> mem_q[$past(wr_addr_r)][35] == ($past(wr_lanes_n_r[3]) ? $past(mem_q[wr_addr_r][35]) : $past(data_in.parity[3])))
      else $error("parity three ignored its byte select");
   read_flow_a: assert property (
      en && op_nxt == ftsram_pkg::FTSRAM_READ && !wr_hit
      |=> data_out == $past(mem_q[cur_addr]))
      else $error("read data not from previous address");
   oe_low_drive_a: assert property (
      en && op_nxt == ftsram_pkg::FTSRAM_READ |=> output_enable_n || (&data_oe))
      else $error("read phase with enable low not driving");
   oe_high_float_a: assert property (
      output_enable_n |-> data_oe == '0)
      else $error("pins driven with enable high");
   write_float_a: assert property (
      write_addr_s |=> wr_pend_r && data_oe == '0)
      else $error("pins driven in write data phase");
   desel_float_a: assert property (
      en && load && !sel_now |=> op_r == ftsram_pkg::FTSRAM_DESEL && data_oe == '0)
      else $error("pins driven while deselected");
   linear_step_a: assert property (
      linear_load_s ##1 (en && !load) |-> burst_lo == 2'($past(address[1:0]) + 2'h1))
      else $error("linear burst step wrong");
   interleave_step_a: assert property (
      il_load_s ##1 (en && !load) |-> burst_lo == ($past(address[1:0]) ^ 2'h1))
      else $error("interleaved burst step wrong");
   stall_hold_a: assert property (
      ctrl.clock_qualifier_n |=> $stable(data_out) && $stable(op_r) && $stable(drive_r))
      else $error("state moved during stall");
endmodule : ftsram_data_io
`default_nettype wire

/* bench/ftsram_ctl_model.sv */
// memory controller side of the data pins with wire resolution
`timescale 1ns/1ps
`default_nettype none
module ftsram_ctl_model (
   input wire logic clock,
   input wire logic drv_en,
   input wire logic [ftsram_pkg::WORD_W-1:0] drv_word,
   input wire logic [ftsram_pkg::WORD_W-1:0] data_out,
   input wire logic [ftsram_pkg::WORD_W-1:0] data_oe,
   output logic [ftsram_pkg::WORD_W-1:0] data_in
);
   logic [ftsram_pkg::WORD_W-1:0] last_r; // last level seen on the pins
   logic [ftsram_pkg::WORD_W-1:0] far_w; // what the controller side puts on the pins
   // released pins show the inverse of the last value, never a stale copy
   assign far_w = drv_en ? drv_word : ~last_r;
   // device drives a bit only where its enable is high
   assign data_in = (data_oe & data_out) | (~data_oe & far_w);
   // remember the pin level for the next release
   always_ff @(posedge clock) begin
      last_r <= data_in;
   end
endmodule : ftsram_ctl_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the flow-through sram data path
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("Error %0t mismatch", $time); end end
module tb;
   logic clock = 1'b0, rst_n = 1'b0, oe_n = 1'b0, strap = 1'b1, drv_en = 1'b0;
   logic [3:0] address = 4'h0;
   ftsram_pkg::ftsram_ctrl_t ctrl = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF};
   ftsram_pkg::ftsram_word_t drv_word = '0, data_in, data_out, mem [16];
   logic [35:0] data_oe;
   logic [15:0] lfsr = 16'hE07A;
   int err_count = 0, comparisons = 0, cycles = 0;
   logic [3:0] last_a = 4'h0; // address of the latest read beat
   ftsram_data_io #(.ADDR_W(4)) dut_u (.clock(clock), .rst_n(rst_n), .address(address), .ctrl(ctrl),
      .output_enable_n(oe_n), .burst_order_strap(strap), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
   ftsram_ctl_model model_u (.clock(clock), .drv_en(drv_en), .drv_word(drv_word), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in));
   // clock and hang limit
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   // fixed-seed pseudo random source
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd
   // expected word after a lane-masked write
   function automatic ftsram_pkg::ftsram_word_t merge(ftsram_pkg::ftsram_word_t o, ftsram_pkg::ftsram_word_t n,
      logic [3:0] lane_n);
      for (int i = 0; i < 4; i++) begin
         if (!lane_n[i]) begin
            o.data[8*i+:8] = n.data[8*i+:8];
            o.parity[i] = n.parity[i];
         end
      end
      return o;
   endfunction : merge
   // expected low address bits of a burst beat
   function automatic logic [1:0] ord(logic [1:0] s, logic [1:0] k, logic il);
      return il ? (s ^ k) : (s + k);
   endfunction : ord
   // one clock: set inputs at the falling edge, settle after the rising one
   task automatic step(logic sel, logic adv, logic we_n, logic [3:0] lane_n, logic [3:0] a, logic den);
      @(negedge clock);
      ctrl.chip_select_one_n = ~sel;
      ctrl.advance_or_load = adv;
      ctrl.write_enable_n = we_n;
      ctrl.byte_write_select_n = lane_n;
      address = a;
      drv_en = den;
      @(posedge clock);
      #1;
   endtask : step
   // write with address edge then data edge; the data edge deselects or reads the same word back
   task automatic wr(logic [3:0] a, logic [3:0] lane_n, logic back = 1'b0);
      step(1'b1, 1'b0, 1'b0, lane_n, a, 1'b0);
      `CHK(data_oe, 36'h0_0000_0000)
      drv_word = 36'({rnd(), rnd(), rnd()});
      step(back, 1'b0, 1'b1, 4'hF, a, 1'b1);
      mem[a] = merge(mem[a], drv_word, lane_n);
      if (back) `CHK(data_out, mem[a])
      else `CHK(data_oe, 36'h0_0000_0000)
   endtask : wr
   // read beat, load or advance, compared against the mirror
   task automatic rd(logic [3:0] a, logic adv);
      step(1'b1, adv, 1'b1, 4'hF, a, 1'b0);
      last_a = a;
      `CHK(data_out, mem[a])
      `CHK(data_oe, 36'hF_FFFF_FFFF)
   endtask : rd
   initial begin
      for (int s = 0; s < 2; s++) begin
         @(negedge clock);
         rst_n = 1'b0;
         strap = s[0];
         repeat (5) @(posedge clock);
         @(negedge clock);
         rst_n = 1'b1;
         step(1'b0, 1'b0, 1'b1, 4'hF, 4'h0, 1'b0);
         for (int a = 0; a < 16; a++) wr(a[3:0], 4'h0);
         for (int i = 0; i < 12; i++) wr(4'(rnd()), 4'((i < 4) ? 16'h1 << i : rnd()), i[0]);
         for (int i = 0; i < 4; i++) begin
            logic [3:0] b;
            b = (i == 0) ? 4'h3 : 4'(rnd());
            rd(b, 1'b0);
            for (int k = 1; k < 4; k++) rd({b[3:2], ord(b[1:0], k[1:0], strap)}, 1'b1);
         end
         // stall: a qualified-off write load is ignored and the read stands
         @(negedge clock);
         ctrl.clock_qualifier_n = 1'b1;
         repeat (3) step(1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 1'b0);
         `CHK(data_out, mem[last_a])
         `CHK(data_oe, 36'hF_FFFF_FFFF)
         // qualifier back with a deselect load; enable high floats at once
         @(negedge clock);
         ctrl.clock_qualifier_n = 1'b0;
         ctrl.chip_select_one_n = 1'b1;
         oe_n = 1'b1;
         #1;
         `CHK(data_oe, 36'h0_0000_0000)
         @(negedge clock);
         oe_n = 1'b0;
         // word zero must not hold the stalled write
         rd(4'h0, 1'b0);
         $display("test with strap %0d done", s);
      end
      print_verdict();
   end
   // counts, verdict and end of run
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
endmodule : tb
`default_nettype wire
